// ---- logic/umc_ir_codec.sv ----
// Infrared pulse encoder and decoder with bypass
`timescale 1ns/10ps
`default_nettype none
`include "umc_params.svh"
module umc_ir_codec #(
	parameter int PULSE = `UMC_IR_PULSE
) (
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic en_i, // Codec enable
	input wire logic tx_i, // Serial out bit
	input wire logic rx_i, // Line in
	output logic tx_o, // Line out
	output logic rx_o // Serial in bit
);
	logic [7:0] cnt;
	logic tx_d;
	wire start = tx_d & ~tx_i;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 8'h00;
			tx_d <= 1'b1;
		end else begin
			tx_d <= tx_i;
			if (start)
				cnt <= 8'(PULSE);
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end
	// Each falling edge of the serial bit becomes a short high pulse; idle line low
	assign tx_o = en_i ? (cnt != 8'h00) : tx_i;
	assign rx_o = en_i ? ~rx_i : rx_i;
endmodule : umc_ir_codec
`default_nettype wire

// ---- logic/umc_mode_ctrl.sv ----
// Serial port mode control: APB registers, pin ownership, wake, loopback
//
// Contract
// R1: Usage 00: only transmit and receive used
// R2: Usage 01: also request-to-send pin used
// R3: Usage 10: clear and request pins used
// R4: Usage 11: drive baud clock output pin
// R5: Wake enabled: receive sampled during sleep
// R6: Wake enabled: falling receive edge interrupts
// R7: Rising edge after wake clears wake enable
// R8: Loopback bit routes transmit to receive
// R9: Auto-baud measures next 55h sync field
// R10: Measurement done clears auto-baud bit
// R11: Mode bit picks simplex or flow control
// R12: Disabled port releases all pins
// R13: Infrared bit inserts codec, else bypass
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "umc_params.svh"
module umc_mode_ctrl #(
	parameter int CLK_DIV_W = 16
) (
	input wire logic MCLK_I, // Peripheral clock, 125 MHz
	input wire logic RST_N_I, // Asynchronous reset, active low
	input wire logic [11:0] PADDR_I, // APB address
	input wire logic PSEL_I, // APB select
	input wire logic PENABLE_I, // APB enable
	input wire logic PWRITE_I, // APB direction
	input wire logic [31:0] PWDATA_I, // APB write data
	output logic [31:0] PRDATA_O, // APB read data
	output logic PREADY_O, // APB ready
	output logic PSLVERR_O, // APB error
	output logic IRQ_O, // Interrupt, level
	input wire logic SLEEP_I, // Device is in sleep
	input wire logic IDLE_I, // Device is in idle
	input wire logic CORE_TX_I, // Serial data from transmitter
	output logic CORE_RX_O, // Serial data to receiver
	input wire logic CORE_RTS_I, // Receiver ready for data
	input wire logic CORE_TXBUSY_I, // Transmitter active
	output logic CORE_CTS_O, // Remote ready to take data
	output logic CORE_ACTIVE_O, // Port logic running
	input wire logic BAUD_CLK_I, // Baud clock from generator
	input wire logic TRANSMIT_PIN_I, // Unused; kept for pad symmetry
	output logic TRANSMIT_PIN_O, // Transmit pin level
	output logic TRANSMIT_PIN_OE_O, // Transmit pin owned
	input wire logic RECEIVE_PIN_I, // Receive pin level
	input wire logic CLEAR_TO_SEND_PIN_I, // Clear-to-send pin
	output logic CLEAR_TO_SEND_PIN_USE_O, // Clear-to-send owned
	output logic REQUEST_TO_SEND_PIN_O, // Request/baud pin level
	output logic REQUEST_TO_SEND_PIN_OE_O, // Request/baud owned
	output logic [CLK_DIV_W-1:0] RATE_DIV_O // Measured cycles/bit
);
	import umc_pkg::*;
	logic [15:0] mode;
	logic [`UMC_EV_N-1:0] stat, mask;
	logic wake_seen, rx_d;
	logic ab_done;
	logic [CLK_DIV_W-1:0] ab_div;
	logic ir_tx, ir_rx;

	wire en = mode[`UMC_BIT_EN];
	wire ir_en = mode[`UMC_BIT_INFRARED_CODEC_ENABLE];
	wire rts_simplex = mode[`UMC_BIT_REQUEST_TO_SEND_PIN_MODE];
	wire wake_en = mode[`UMC_BIT_WAKE];
	wire lpbk = mode[`UMC_BIT_LPBK];
	wire ab_en = mode[`UMC_BIT_AUTO_RATE_DETECT];
	wire rx_inv = mode[`UMC_BIT_RXINV];
	umc_pins_t pins;
	assign pins = umc_pins_t'(mode[`UMC_BIT_PIN_HI:`UMC_BIT_PIN_LO]);

	// Idle stop and sleep hold the receive output idle and disarm rate detection; the wake watcher runs in both
	wire run = en & ~(IDLE_I & mode[`UMC_BIT_SIDL]) & ~SLEEP_I;

	// APB decode
	wire acc = PSEL_I & PENABLE_I;
	wire wr = acc & PWRITE_I;
	wire hit_mode = PADDR_I == `UMC_MODE_OFF;
	wire hit_stat = PADDR_I == `UMC_STAT_OFF;
	wire hit_mask = PADDR_I == `UMC_MASK_OFF;
	wire hit_rate = PADDR_I == `UMC_RATE_OFF;
	wire hit_any = hit_mode | hit_stat | hit_mask | hit_rate;
	wire wr_mode = wr & hit_mode;
	wire wr_stat = wr & hit_stat;
	wire wr_mask = wr & hit_mask;
	wire [31:0] rd_data = hit_mode ? {16'h0000, mode} :
		hit_stat ? {{(32-`UMC_EV_N){1'b0}}, stat} :
		hit_mask ? {{(32-`UMC_EV_N){1'b0}}, mask} :
		hit_rate ? {{(32-CLK_DIV_W){1'b0}}, ab_div} : 32'h0000_0000;

	// Receive path: line, optional inversion, codec, loopback
	wire rx_line = RECEIVE_PIN_I ^ rx_inv;
	wire wake_fall = en & wake_en & rx_d & ~rx_line; // R5 R6
	wire wake_rise = wake_seen & ~rx_d & rx_line; // R7
	wire rx_ser = lpbk ? CORE_TX_I : ir_rx; // R8

	umc_ir_codec u_ir (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.en_i(ir_en), // R13
		.tx_i(CORE_TX_I),
		.rx_i(rx_line),
		.tx_o(ir_tx),
		.rx_o(ir_rx)
	);

	umc_rate_meas #(.W(CLK_DIV_W)) u_ab (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.arm_i(ab_en & run), // R9 R10
		.rx_i(rx_ser),
		.done_o(ab_done),
		.div_o(ab_div)
	);

	// Pin ownership by usage field
	wire use_rts = en &
		(pins == UMC_PINS_RTS || pins == UMC_PINS_FLOW); // R1 R2 R3 R12
	wire use_clk = en & (pins == UMC_PINS_CLK); // R4
	wire use_cts = en & (pins == UMC_PINS_FLOW); // R3
	// Simplex: assert while sending; flow control: receiver readiness
	wire rts_lvl = rts_simplex ? ~CORE_TXBUSY_I : ~CORE_RTS_I; // R11
	wire next_rts = use_clk ? BAUD_CLK_I : rts_lvl;
	wire next_tx = ~en | lpbk | ir_tx; // R8 R12
	wire [`UMC_EV_N-1:0] ev = {ab_done, wake_fall};

	// Mode register with hardware clears
	logic [15:0] next_mode;
	always_comb begin
		next_mode = mode;
		if (wr_mode)
			next_mode = PWDATA_I[15:0] & `UMC_MODE_WMASK;
		if (wake_rise)
			next_mode[`UMC_BIT_WAKE] = 1'b0; // R7
		if (ab_done)
			next_mode[`UMC_BIT_AUTO_RATE_DETECT] = 1'b0; // R10
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mode <= `UMC_MODE_RST;
			mask <= '0;
			rx_d <= 1'b1;
			wake_seen <= 1'b0;
		end else begin
			mode <= next_mode;
			rx_d <= rx_line; // R5
			if (wr_mask)
				mask <= PWDATA_I[`UMC_EV_N-1:0];
			if (wake_fall)
				wake_seen <= 1'b1; // R7
			else if (wake_rise || !wake_en)
				wake_seen <= 1'b0;
		end
	end

	// Sticky events: set wins over write-one-to-clear
	genvar g;
	generate
		for (g = 0; g < `UMC_EV_N; g++) begin : g_ev
			always_ff @(posedge MCLK_I or negedge RST_N_I) begin
				if (!RST_N_I)
					stat[g] <= 1'b0;
				else if (ev[g])
					stat[g] <= 1'b1; // R6
				else if (wr_stat && PWDATA_I[g])
					stat[g] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PRDATA_O <= 32'h0000_0000;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			IRQ_O <= 1'b0;
		end else begin
			// One wait state: answer in the second access cycle
			PREADY_O <= acc & ~PREADY_O;
			PSLVERR_O <= acc & ~PREADY_O & ~hit_any;
			PRDATA_O <= (acc & ~PREADY_O & ~PWRITE_I) ? rd_data : 32'h0;
			IRQ_O <= |(stat & mask);
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			TRANSMIT_PIN_O <= 1'b1;
			TRANSMIT_PIN_OE_O <= 1'b0;
			CORE_RX_O <= 1'b1;
			CORE_CTS_O <= 1'b1;
			CORE_ACTIVE_O <= 1'b0;
			CLEAR_TO_SEND_PIN_USE_O <= 1'b0;
			REQUEST_TO_SEND_PIN_O <= 1'b1;
			REQUEST_TO_SEND_PIN_OE_O <= 1'b0;
			RATE_DIV_O <= '0;
		end else begin
			TRANSMIT_PIN_O <= next_tx;
			TRANSMIT_PIN_OE_O <= en; // R1 R12
			CORE_RX_O <= run ? rx_ser : 1'b1; // R12
			CORE_CTS_O <= use_cts ? ~CLEAR_TO_SEND_PIN_I : 1'b1; // R3
			CORE_ACTIVE_O <= run;
			CLEAR_TO_SEND_PIN_USE_O <= use_cts; // R3
			REQUEST_TO_SEND_PIN_O <= next_rts;
			REQUEST_TO_SEND_PIN_OE_O <= use_rts | use_clk; // R2 R4
			RATE_DIV_O <= ab_div;
		end
	end
endmodule : umc_mode_ctrl
`default_nettype wire

// ---- logic/umc_params.svh ----
// Register offsets, field positions and reset values of the mode control block
`ifndef UMC_PARAMS_SVH
`define UMC_PARAMS_SVH
`define UMC_MODE_OFF 12'h000
`define UMC_STAT_OFF 12'h004
`define UMC_MASK_OFF 12'h008
`define UMC_RATE_OFF 12'h00c
`define UMC_MODE_RST 16'h0000
`define UMC_BIT_STOP_BIT_SELECT 0
`define UMC_BIT_PARITY_LENGTH_SELECT_LO 1
`define UMC_BIT_PARITY_LENGTH_SELECT_HI 2
`define UMC_BIT_HSRATE 3
`define UMC_BIT_RXINV 4
`define UMC_BIT_AUTO_RATE_DETECT 5
`define UMC_BIT_LPBK 6
`define UMC_BIT_WAKE 7
`define UMC_BIT_PIN_LO 8
`define UMC_BIT_PIN_HI 9
`define UMC_BIT_REQUEST_TO_SEND_PIN_MODE 11
`define UMC_BIT_INFRARED_CODEC_ENABLE 12
`define UMC_BIT_SIDL 13
`define UMC_BIT_EN 15
`define UMC_MODE_WMASK 16'hbbff
`define UMC_EV_WAKE 0
`define UMC_EV_RATE 1
`define UMC_EV_N 2
`define UMC_SYNC_EDGES 5
`define UMC_IR_PULSE 16
`endif

// ---- logic/umc_pkg.sv ----
// Types of the mode control block
`default_nettype none
package umc_pkg;
	typedef enum logic [1:0] {
		UMC_PINS_TXRX = 2'b00,
		UMC_PINS_RTS = 2'b01,
		UMC_PINS_FLOW = 2'b10,
		UMC_PINS_CLK = 2'b11
	} umc_pins_t;
	typedef enum logic [3:0] {
		UMC_AB_IDLE = 4'b0001,
		UMC_AB_ARM = 4'b0010,
		UMC_AB_MEAS = 4'b0100,
		UMC_AB_DONE = 4'b1000
	} umc_ab_t;
endpackage : umc_pkg
`default_nettype wire

// ---- logic/umc_rate_meas.sv ----
// Sync field timer for automatic rate detection
`timescale 1ns/10ps
`default_nettype none
`include "umc_params.svh"
module umc_rate_meas #(
	parameter int W = 16
) (
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic arm_i, // Measurement requested
	input wire logic rx_i, // Receive line
	output logic done_o, // One-cycle completion pulse
	output logic [W-1:0] div_o // Cycles per bit
);
	import umc_pkg::*;
	umc_ab_t st, next_st;
	logic [W+2:0] cnt;
	logic [2:0] edges;
	logic rx_d;
	wire fall = rx_d & ~rx_i;
	always_comb begin
		next_st = st;
		case (st)
			UMC_AB_IDLE: if (arm_i) next_st = UMC_AB_ARM;
			UMC_AB_ARM: if (!arm_i) next_st = UMC_AB_IDLE;
				else if (fall) next_st = UMC_AB_MEAS;
			// First fall is taken while armed
			UMC_AB_MEAS: if (!arm_i) next_st = UMC_AB_IDLE;
				else if (fall && edges == 3'(`UMC_SYNC_EDGES - 2))
					next_st = UMC_AB_DONE;
			UMC_AB_DONE: next_st = UMC_AB_IDLE;
			default: next_st = UMC_AB_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= UMC_AB_IDLE;
			cnt <= '0;
			edges <= 3'h0;
			rx_d <= 1'b1;
			div_o <= '0;
		end else begin
			st <= next_st;
			rx_d <= rx_i;
			if (st == UMC_AB_ARM) begin
				// Cycle of the first fall counts as one
				cnt <= {{(W+2){1'b0}}, 1'b1};
				edges <= 3'h0;
			end else if (st == UMC_AB_MEAS) begin
				cnt <= cnt + 1'b1;
				if (fall)
					edges <= edges + 3'h1;
			end
			// Start to fifth falling edge spans eight bits
			if (next_st == UMC_AB_DONE)
				div_o <= cnt[W+2:3];
		end
	end
	assign done_o = (st == UMC_AB_DONE);
endmodule : umc_rate_meas
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the mode control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sleep = 0;
	logic [11:0] pad = 0;
	logic [31:0] pwd = 0, prd, d, rv = 0;
	logic rdy, err, irq, crx, cts, txp, txoe, cuse, rtsp, rtsoe, act, line;
	logic ctx = 1, rts = 0, busy = 0, bclk = 0, cpin = 1, rnd_on = 1;
	logic [15:0] div;
	logic [32:0] q[$];
	int fail_count = 0, checks = 0;
	umc_mode_ctrl umc_mode_ctrl_i (.MCLK_I(clk), .RST_N_I(rst_n),
		.PADDR_I(pad), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
		.IRQ_O(irq), .SLEEP_I(sleep), .IDLE_I(1'b0), .CORE_TX_I(ctx),
		.CORE_RX_O(crx), .CORE_RTS_I(rts), .CORE_TXBUSY_I(busy),
		.CORE_CTS_O(cts), .CORE_ACTIVE_O(act), .BAUD_CLK_I(bclk),
		.TRANSMIT_PIN_I(1'b1), .TRANSMIT_PIN_O(txp), .TRANSMIT_PIN_OE_O(txoe),
		.RECEIVE_PIN_I(line), .CLEAR_TO_SEND_PIN_I(cpin),
		.CLEAR_TO_SEND_PIN_USE_O(cuse), .REQUEST_TO_SEND_PIN_O(rtsp),
		.REQUEST_TO_SEND_PIN_OE_O(rtsoe), .RATE_DIV_O(div));
	umc_remote umc_remote_i (.clk_i(clk), .line_o(line));
	initial forever #4 clk = ~clk;
	// Sole user of the random generator, so one seed covers the run
	initial begin
		void'($urandom(94035));
		forever @(posedge clk) begin
			rv <= $urandom;
			if (rnd_on)
				{rts, busy, bclk, cpin, ctx} <= rv[4:0];
		end
	end
	task automatic chk(input string nm, input logic [32:0] e, s);
		checks++;
		if (e !== s) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		{psel, pen, pwr, pad, pwd} <= {2'b10, w, a, v};
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (rdy !== 1'b1) begin
			chk("pready timeout", 0, 1);
			results();
		end
		{psel, pen} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// Read results against the oldest note
	always @(posedge clk) begin
		if (rdy === 1'b1 && !pwr) begin
			if (q.size() == 0)
				chk("unexpected read", 0, 1);
			else
				chk("read data", q.pop_front(), {err, prd});
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(12'h000, 0);
		rd(12'h004, 0);
		rd(12'h008, 0);
		rd(12'h010, {1'b1, 32'h0});
		$display("test reset done");
		repeat (8) begin
			@(posedge clk);
			d = rv & 32'hffffff5f;
			apb(1'b1, 12'h000, d);
			rd(12'h000, {17'h0, d[15:0] & 16'hbbff});
		end
		for (int u = 0; u < 4; u++) begin
			apb(1'b1, 12'h000, 32'(32'h8000 | u << 8 | (u & 1) << 11));
			repeat (8) @(posedge clk);
		end
		$display("test modes done");
		apb(1'b1, 12'h008, 32'h3);
		apb(1'b1, 12'h000, 32'h8080);
		sleep <= 1'b1;
		umc_remote_i.send(8'hff, 4);
		chk("active in sleep", 0, 33'(act));
		sleep <= 1'b0;
		rd(12'h004, 33'h1);
		rd(12'h000, 33'h8000);
		chk("wake irq", 1, 33'(irq));
		chk("active", 1, 33'(act));
		apb(1'b1, 12'h004, 32'h1);
		rd(12'h004, 0);
		repeat (2) @(posedge clk);
		chk("irq cleared", 0, 33'(irq));
		$display("test wake done");
		apb(1'b1, 12'h000, 32'h8020);
		umc_remote_i.send(8'h55, 10);
		repeat (4) @(posedge clk);
		rd(12'h00c, 33'd10);
		rd(12'h000, 33'h8000);
		rd(12'h004, 33'h2);
		chk("rate pin", 33'd10, 33'(div));
		chk("rate irq", 1, 33'(irq));
		apb(1'b1, 12'h008, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq masked", 0, 33'(irq));
		apb(1'b1, 12'h004, 32'h2);
		rd(12'h004, 0);
		$display("test rate done");
		rnd_on <= 1'b0;
		apb(1'b1, 12'h000, 32'h8040);
		for (int b = 0; b < 2; b++) begin
			ctx <= b[0];
			repeat (4) @(posedge clk);
			chk("loop rx", 33'(b), 33'(crx));
			chk("loop tx pin", 1, 33'(txp));
		end
		apb(1'b1, 12'h000, 32'h9000);
		repeat (20) @(posedge clk);
		chk("ir idle", 0, 33'(txp));
		ctx <= 1'b0;
		repeat (3) @(posedge clk);
		chk("ir pulse", 1, 33'(txp));
		repeat (24) @(posedge clk);
		chk("ir pulse end", 0, 33'(txp));
		apb(1'b1, 12'h000, 32'h0);
		repeat (3) @(posedge clk);
		chk("rx off", 1, 33'(crx));
		chk("inactive", 0, 33'(act));
		$display("test loopback done");
		@(posedge clk);
		results();
	end
endmodule : testbench
`default_nettype wire

// ---- tb/umc_mode_ctrl_props.sv ----
// Assertions on pin ownership of the mode control block
`timescale 1ns/10ps
`default_nettype none
module umc_mode_ctrl_props (
	input wire logic MCLK_I, // Clock
	input wire logic RST_N_I, // Reset
	input wire logic [11:0] PADDR_I, // Address
	input wire logic PSEL_I, // Select
	input wire logic PENABLE_I, // Enable
	input wire logic PWRITE_I, // Direction
	input wire logic [31:0] PWDATA_I, // Write data
	input wire logic CORE_RTS_I, // Receiver ready
	input wire logic CORE_TXBUSY_I, // Sending
	input wire logic BAUD_CLK_I, // Baud clock
	input wire logic CLEAR_TO_SEND_PIN_I, // Clear pin
	input wire logic CORE_CTS_O, // Clear to core
	input wire logic TRANSMIT_PIN_O, // Tx pin
	input wire logic TRANSMIT_PIN_OE_O, // Tx owned
	input wire logic CLEAR_TO_SEND_PIN_USE_O, // Clear owned
	input wire logic REQUEST_TO_SEND_PIN_O, // Request pin
	input wire logic REQUEST_TO_SEND_PIN_OE_O // Request owned
);
	logic [15:0] md;
	wire on = md[15];
	wire [1:0] us = md[9:8];
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// Shadow of the mode word; only fields software alone changes
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			md <= 16'h0000;
		else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 12'h000)
			md <= PWDATA_I[15:0];
	end
	property p_cts_use; on && us == 2'b10 |=> CLEAR_TO_SEND_PIN_USE_O; endproperty
	a_cts_use: assert property (p_cts_use) else $error("cts not taken");
	property p_cts_free; !(on && us == 2'b10) |=> !CLEAR_TO_SEND_PIN_USE_O;
	endproperty
	a_cts_free: assert property (p_cts_free) else $error("cts taken");
	property p_rts_oe; on && us != 2'b00 |=> REQUEST_TO_SEND_PIN_OE_O; endproperty
	a_rts_oe: assert property (p_rts_oe) else $error("rts not driven");
	property p_rts_free; !(on && us != 2'b00) |=> !REQUEST_TO_SEND_PIN_OE_O;
	endproperty
	a_rts_free: assert property (p_rts_free) else $error("rts driven");
	property p_bclk; on && us == 2'b11
		|=> REQUEST_TO_SEND_PIN_O == $past(BAUD_CLK_I); endproperty
	a_bclk: assert property (p_bclk) else $error("baud clock wrong");
	property p_simplex; on && us == 2'b01 && md[11]
		|=> REQUEST_TO_SEND_PIN_O == !$past(CORE_TXBUSY_I); endproperty
	a_simplex: assert property (p_simplex) else $error("simplex wrong");
	property p_flow; on && us == 2'b10 && !md[11]
		|=> REQUEST_TO_SEND_PIN_O == !$past(CORE_RTS_I); endproperty
	a_flow: assert property (p_flow) else $error("flow wrong");
	property p_cts_val; on && us == 2'b10
		|=> CORE_CTS_O == !$past(CLEAR_TO_SEND_PIN_I); endproperty
	a_cts_val: assert property (p_cts_val) else $error("cts level wrong");
	property p_off; !on |=> !TRANSMIT_PIN_OE_O && TRANSMIT_PIN_O && CORE_CTS_O;
	endproperty
	a_off: assert property (p_off) else $error("pins not released");
	property p_loop; on && md[6] |=> TRANSMIT_PIN_O; endproperty
	a_loop: assert property (p_loop) else $error("tx pin not idle");
endmodule : umc_mode_ctrl_props
bind umc_mode_ctrl umc_mode_ctrl_props umc_mode_ctrl_props_i (.*);
`default_nettype wire

// ---- tb/umc_remote.sv ----
// Remote serial device driving the receive line
`timescale 1ns/10ps
`default_nettype none
module umc_remote (
	input wire logic clk_i, // Clock
	output logic line_o // Receive line, idles high
);
	initial line_o = 1'b1;
	// Start bit, eight data bits lsb first, stop bit; t cycles per bit
	task automatic send(input logic [7:0] b, input int t);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			line_o <= fr[i];
			repeat (t - 1) @(posedge clk_i);
		end
	endtask : send
endmodule : umc_remote
`default_nettype wire
